// ===== hbli_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Detect strobe style, default separate strobes
// - Strobe style fixed until hardware reset
// - Address bit activity means non-multiplexed; default mux
// - Select with read strobe line low after first write freezes both detections
// - Registers direct, RAM through pointer only
// - No waits; slowdown spaces arbitration only
// - Pointer auto-increment or fixed mode
// - RAM fetch on pointer-low write or auto-increment data read
// - New read pointer prefetches immediately
// - Data write latched then stored to RAM
// - Backplane transmit open-drain or push-pull
// - One is 100 ns low pulse
// - Low receive pulse means one
// - Auxiliary output gives line clock
// - Pulses only while transmit enable active
// - Reset holds line outputs inactive; enable held high, active if strap grounded
// - Auxiliary pin strap sets enable polarity
// - Line idles zero; byte eleven intervals
module hbli_top
    import hbli_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Host bus
    input  wire hbli_pkg::hbli_host_s host,
    output logic [7:0]            host_rdata,
    output logic                  strobe_style,
    output logic                  bus_nonmux,
    output logic                  detect_final,
    // Line configuration and transmit request
    input  wire hbli_pkg::hbli_cfg_s cfg,
    input  wire logic             tx_start,
    input  wire logic [7:0]       tx_byte,
    output logic                  tx_busy,
    // Line pins
    output logic                  line_tx_pulse_n,
    output logic                  line_tx_pulse_oe,
    input  wire logic             line_aux_in,
    output logic                  line_aux_pulse_n,
    output logic                  line_aux_oe,
    input  wire logic             line_rx_in,
    output logic                  tx_enable_pin,
    // Receive result and arbitration grant
    output logic [7:0]            rx_byte,
    output logic                  rx_valid,
    output logic                  arb_grant
);
    import hbli_pkg::*;

    // Host side state
    logic                  style_q, style_d;      // Strobe style decision
    logic                  mux_q, mux_d;          // High for non-multiplexed
    logic                  final_q, final_d;      // Detections frozen
    logic                  seen_q, seen_d;        // First write seen
    logic [HBLI_RAM_AW-1:0] ptr_q, ptr_d;         // RAM pointer
    logic                  autoinc_q, autoinc_d;  // Pointer mode
    logic                  rdmode_q, rdmode_d;    // Pointer loaded for reads
    logic [7:0]            data_q, data_d;        // Data register
    logic                  fetch_q, fetch_d;      // Prefetch pending
    logic                  store_q, store_d;      // Store pending
    logic [7:0]            rdata_q, rdata_d;
    logic                  prev_wr_q, prev_rd_q, prev_wr_d, prev_rd_d;
    logic [7:0]            ram [HBLI_RAM_DEPTH];  // Internal buffer memory
    logic [7:0]            arb_cnt_q, arb_cnt_d;  // Arbitration spacing
    logic                  grant_q, grant_d;

    // Decoded strobes for the current style
    logic rd_act, wr_act, rd_edge, wr_edge;
    always_comb begin
        if (style_q == HBLI_STROBE_DIR_DS) begin
            rd_act = !host.chip_select_n && !host.write_strobe_n && host.read_strobe_n;
            wr_act = !host.chip_select_n && !host.write_strobe_n && !host.read_strobe_n;
        end else begin
            rd_act = !host.chip_select_n && !host.read_strobe_n;
            wr_act = !host.chip_select_n && !host.write_strobe_n;
        end
        rd_edge = rd_act && !prev_rd_q;
        wr_edge = wr_act && !prev_wr_q;
    end

    // Pointer advance, used on both read and write paths
    function automatic logic [HBLI_RAM_AW-1:0] next_ptr(
        input logic [HBLI_RAM_AW-1:0] p,
        input logic                   inc
    );
        next_ptr = inc ? p + 11'h001 : p;
    endfunction

    // Host bus next state; registers answer in the cycle after the strobe
    always_comb begin
        style_d = style_q;
        mux_d = mux_q;
        final_d = final_q;
        seen_d = seen_q;
        ptr_d = ptr_q;
        autoinc_d = autoinc_q;
        rdmode_d = rdmode_q;
        data_d = data_q;
        fetch_d = 1'b0;
        store_d = 1'b0;
        rdata_d = rdata_q;
        prev_rd_d = rd_act;
        prev_wr_d = wr_act;
        if (!final_q) begin
            // Style two drives the direction low with a data strobe on the other line
            if (!seen_q && !host.chip_select_n && !host.write_strobe_n) begin
                seen_d = 1'b1;
                style_d = host.read_strobe_n ? HBLI_STROBE_SEPARATE : HBLI_STROBE_DIR_DS;
            end
            // A real address on the latch-free bus shows non-multiplexed wiring
            if (!host.chip_select_n && host.addr[0] && !host.ale) begin
                mux_d = 1'b1;
            end
            if (!host.chip_select_n && !host.read_strobe_n && seen_q) begin
                final_d = 1'b1;
            end
        end
        // Direct register decode
        if (wr_edge) begin
            unique case (host.addr)
                HBLI_REG_PTR_HIGH: begin
                    autoinc_d = host.wdata[HBLI_PH_AUTOINC];
                    rdmode_d = host.wdata[HBLI_PH_RDDATA];
                    ptr_d = {host.wdata[2:0], ptr_q[7:0]};
                end
                HBLI_REG_PTR_LOW: begin
                    ptr_d = {ptr_q[10:8], host.wdata};
                    fetch_d = rdmode_q;
                end
                HBLI_REG_DATA: begin
                    data_d = host.wdata;
                    store_d = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd_edge) begin
            unique case (host.addr)
                HBLI_REG_STATUS:   rdata_d = {5'h00, final_q, mux_q, style_q};
                HBLI_REG_PTR_HIGH: rdata_d = {rdmode_q, autoinc_q, 3'h0, ptr_q[10:8]};
                HBLI_REG_PTR_LOW:  rdata_d = ptr_q[7:0];
                HBLI_REG_DATA: begin
                    rdata_d = data_q;
                    // Reading alone never fetches unless auto-increment moves on
                    if (autoinc_q) begin
                        ptr_d = next_ptr(ptr_q, 1'b1);
                        fetch_d = rdmode_q;
                    end
                end
                default:           rdata_d = 8'h00;
            endcase
        end
        if (fetch_q) begin
            data_d = ram[ptr_q];
        end
        if (store_q) begin
            ptr_d = next_ptr(ptr_q, autoinc_q);
        end
    end

    // RAM write one cycle after the data latch
    always_ff @(posedge clk) begin
        if (store_q) begin
            ram[ptr_q] <= data_q;
        end
    end

    // Arbitration grant: slowdown only widens the gap
    always_comb begin
        grant_d = 1'b0;
        arb_cnt_d = arb_cnt_q - 8'h01;
        if (arb_cnt_q == 8'h00) begin
            grant_d = 1'b1;
            arb_cnt_d = cfg.arbiter_slowdown ? HBLI_ARB_SLOW : HBLI_ARB_FAST;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            style_q <= HBLI_STROBE_SEPARATE;
            mux_q <= 1'b0;
            final_q <= 1'b0;
            seen_q <= 1'b0;
            ptr_q <= '0;
            autoinc_q <= 1'b0;
            rdmode_q <= 1'b0;
            data_q <= 8'h00;
            fetch_q <= 1'b0;
            store_q <= 1'b0;
            rdata_q <= 8'h00;
            prev_rd_q <= 1'b0;
            prev_wr_q <= 1'b0;
            arb_cnt_q <= 8'h00;
            grant_q <= 1'b0;
        end else begin
            style_q <= style_d;
            mux_q <= mux_d;
            final_q <= final_d;
            seen_q <= seen_d;
            ptr_q <= ptr_d;
            autoinc_q <= autoinc_d;
            rdmode_q <= rdmode_d;
            data_q <= data_d;
            fetch_q <= fetch_d;
            store_q <= store_d;
            rdata_q <= rdata_d;
            prev_rd_q <= prev_rd_d;
            prev_wr_q <= prev_wr_d;
            arb_cnt_q <= arb_cnt_d;
            grant_q <= grant_d;
        end
    end

    // Line transmitter and receiver state
    logic [7:0]  ucnt_q, ucnt_d;    // Cycle within unit interval
    logic [3:0]  ui_q, ui_d;        // Interval within byte
    logic [10:0] sh_q, sh_d;        // Eleven-interval frame
    logic        busy_q, busy_d;
    logic        pol_q, pol_d;      // Enable active high when strap grounded
    logic        strap_q, strap_d;  // Strap captured once after release
    logic        txp_q, txp_d, aux_q, aux_d, en_q, en_d;
    logic        txoe_q, txoe_d, auxoe_q, auxoe_d;  // Driver enables, registered like the pins
    logic [7:0]  plow_q, plow_d;    // Low run of the transmit pulse, checking aid
    logic [9:0]  brun_q, brun_d;    // Busy run of one frame, checking aid
    logic        rx_prev_q, rx_prev_d;
    logic [3:0]  rxc_q, rxc_d;
    logic [7:0]  rxs_q, rxs_d, rxb_q, rxb_d;
    logic        rxv_q, rxv_d, rxhit_q, rxhit_d;
    logic [7:0]  rcnt_q, rcnt_d;

    always_comb begin
        ucnt_d = ucnt_q;
        ui_d = ui_q;
        sh_d = sh_q;
        busy_d = busy_q;
        strap_d = 1'b1;
        pol_d = strap_q ? pol_q : !line_aux_in;
        // Frame is two marks, one space, eight data bits, idle is zero
        if (!busy_q && tx_start) begin
            busy_d = 1'b1;
            sh_d = {2'b11, 1'b0, tx_byte};
            ucnt_d = 8'h00;
            ui_d = 4'h0;
        end else if (busy_q) begin
            ucnt_d = ucnt_q + 8'h01;
            if (ucnt_q == 8'(HBLI_UI_CYC - 1)) begin
                ucnt_d = 8'h00;
                sh_d = {sh_q[9:0], 1'b0};
                ui_d = ui_q + 4'h1;
                if (ui_q == 4'(HBLI_BYTE_UI - 1)) begin
                    busy_d = 1'b0;
                end
            end
        end
        // Fresh polarity, so the first clocked enable value already follows the strap
        en_d = busy_d ? pol_d : !pol_d;
        // Low pulse for first half of a one interval
        txp_d = !(busy_q && sh_q[10] && ucnt_q < 8'(HBLI_PULSE_CYC));
        aux_d = !(busy_q && cfg.backplane && ucnt_q < 8'(HBLI_PULSE_CYC));
        txoe_d = cfg.tx_driver_style ? 1'b1 : !txp_d;
        auxoe_d = strap_d && cfg.backplane;
        plow_d = txp_q ? 8'h00 : plow_q + 8'h01;
        brun_d = busy_q ? brun_q + 10'h001 : 10'h000;
        // Receiver: a falling edge in the interval marks a one
        rx_prev_d = line_rx_in;
        rxhit_d = rxhit_q || (rx_prev_q && !line_rx_in);
        rcnt_d = rcnt_q + 8'h01;
        rxc_d = rxc_q;
        rxs_d = rxs_q;
        rxb_d = rxb_q;
        rxv_d = 1'b0;
        if (rxc_q == 4'h0 && rxhit_d) begin
            rxc_d = 4'h1;
            // Close each interval half-way, so a pulse never meets the boundary
            rcnt_d = 8'(HBLI_UI_CYC / 2);
            rxhit_d = 1'b0;
        end else if (rxc_q != 4'h0 && rcnt_q == 8'(HBLI_UI_CYC - 1)) begin
            rcnt_d = 8'h00;
            rxhit_d = 1'b0;
            if (rxc_q >= 4'h4) begin  // Intervals four onward carry data
                rxs_d = {rxs_q[6:0], rxhit_q};
            end
            rxc_d = rxc_q + 4'h1;
            if (rxc_q == 4'(HBLI_BYTE_UI)) begin
                rxc_d = 4'h0;
                rxb_d = {rxs_q[6:0], rxhit_q};
                rxv_d = 1'b1;
            end
        end
    end

    // Reset drives line outputs inactive and the enable high, active with a grounded strap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ucnt_q <= 8'h00;
            ui_q <= 4'h0;
            sh_q <= '0;
            busy_q <= 1'b0;
            pol_q <= 1'b0;
            strap_q <= 1'b0;
            txp_q <= 1'b1;
            aux_q <= 1'b1;
            en_q <= 1'b1;
            txoe_q <= 1'b0;
            auxoe_q <= 1'b0;
            plow_q <= 8'h00;
            brun_q <= 10'h000;
            rx_prev_q <= 1'b1;
            rxc_q <= 4'h0;
            rxs_q <= 8'h00;
            rxb_q <= 8'h00;
            rxv_q <= 1'b0;
            rxhit_q <= 1'b0;
            rcnt_q <= 8'h00;
        end else begin
            ucnt_q <= ucnt_d;
            ui_q <= ui_d;
            sh_q <= sh_d;
            busy_q <= busy_d;
            pol_q <= pol_d;
            strap_q <= strap_d;
            txp_q <= txp_d;
            aux_q <= aux_d;
            en_q <= en_d;
            txoe_q <= txoe_d;
            auxoe_q <= auxoe_d;
            plow_q <= plow_d;
            brun_q <= brun_d;
            rx_prev_q <= rx_prev_d;
            rxc_q <= rxc_d;
            rxs_q <= rxs_d;
            rxb_q <= rxb_d;
            rxv_q <= rxv_d;
            rxhit_q <= rxhit_d;
            rcnt_q <= rcnt_d;
        end
    end

    // Output pins; open-drain drives only the low level
    assign line_tx_pulse_n  = txp_q;
    assign line_tx_pulse_oe = txoe_q;
    assign line_aux_pulse_n = aux_q;
    assign line_aux_oe      = auxoe_q;
    assign tx_enable_pin    = en_q;
    assign tx_busy          = busy_q;
    assign host_rdata       = rdata_q;
    assign strobe_style     = style_q;
    assign bus_nonmux       = mux_q;
    assign detect_final     = final_q;
    assign rx_byte          = rxb_q;
    assign rx_valid         = rxv_q;
    assign arb_grant        = grant_q;

    // Checks
    frozen_style_a: assert property (@(posedge clk) disable iff (reset)
        final_q |=> $stable(style_q) && $stable(mux_q)) else $error("mode changed");
    style_lock_a: assert property (@(posedge clk) disable iff (reset)
        seen_q |=> $stable(style_q)) else $error("style changed");
    no_idle_pulse_a: assert property (@(posedge clk) disable iff (reset)
        !busy_q |=> txp_q) else $error("pulse while idle");
    // Run counters replace long repetitions, which the tools unroll badly
    pulse_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(txp_q) |-> plow_q == 8'(HBLI_PULSE_CYC)) else $error("pulse width");
    fetch_src_a: assert property (@(posedge clk) disable iff (reset)
        fetch_q |=> data_q == $past(ram[ptr_q])) else $error("prefetch wrong");
    read_nofetch_a: assert property (@(posedge clk) disable iff (reset)
        (rd_edge && !autoinc_q && !wr_edge) |=> !fetch_q) else $error("read fetched");
    inc_step_a: assert property (@(posedge clk) disable iff (reset)
        (store_q && autoinc_q && !wr_edge) |=> ptr_q == $past(ptr_q) + 11'h001)
        else $error("no advance");
    byte_len_a: assert property (@(posedge clk) disable iff (reset)
        $fell(busy_q) |-> brun_q == 10'(HBLI_UI_CYC * HBLI_BYTE_UI))
        else $error("frame length");
endmodule

// ===== hbli_pkg.sv
package hbli_pkg;
    // Host bus strobe style
    typedef enum logic [0:0] {
        HBLI_STROBE_SEPARATE = 1'b0,  // Separate read and write strobes
        HBLI_STROBE_DIR_DS   = 1'b1   // Direction line plus data strobe
    } hbli_strobe_e;

    // Register indices on the host address bus
    localparam logic [2:0] HBLI_REG_STATUS   = 3'h0;
    localparam logic [2:0] HBLI_REG_PTR_HIGH = 3'h2;
    localparam logic [2:0] HBLI_REG_PTR_LOW  = 3'h3;
    localparam logic [2:0] HBLI_REG_DATA     = 3'h4;

    // Pointer high field positions
    localparam int HBLI_PH_RDDATA  = 7;
    localparam int HBLI_PH_AUTOINC = 6;

    // Memory geometry
    localparam int HBLI_RAM_AW    = 11;
    localparam int HBLI_RAM_DEPTH = 2048;

    // Line timing
    localparam int HBLI_CLK_MHZ    = 200;
    localparam int HBLI_PULSE_NS   = 100;
    localparam int HBLI_PULSE_CYC  = (HBLI_PULSE_NS * HBLI_CLK_MHZ) / 1000;
    localparam int HBLI_UI_CYC     = 2 * HBLI_PULSE_CYC;
    localparam int HBLI_BYTE_UI    = 11;
    localparam logic [7:0] HBLI_ARB_FAST = 8'h00;
    localparam logic [7:0] HBLI_ARB_SLOW = 8'h03;

    // Host bus sample
    typedef struct packed {
        logic       chip_select_n;
        logic       read_strobe_n;   // Read strobe, or direction in strobe style two
        logic       write_strobe_n;  // Write strobe, or data strobe in style two
        logic       ale;             // Address latch for multiplexed bus
        logic [2:0] addr;            // Register address, bit 0 is lowest_address_line
        logic [7:0] wdata;
    } hbli_host_s;

    // Line configuration
    typedef struct packed {
        logic backplane;
        logic tx_driver_style;  // High selects push-pull
        logic arbiter_slowdown;
    } hbli_cfg_s;
endpackage

// ===== hbli_line_model.sv
`timescale 1ns/1ps
// Far side of the line pins: one backplane wire with its pull-up,
// looped back into the receiver, plus the strap on the auxiliary pin
module hbli_line_model #(
    parameter logic STRAP_GROUND = 1'b1  // Grounded strap asks for active-high enable
) (
    // Transmit pin and its driver enable
    input  wire logic line_tx_pulse_n,
    input  wire logic line_tx_pulse_oe,
    // Auxiliary pin, strap and clock output
    input  wire logic line_aux_pulse_n,
    input  wire logic line_aux_oe,
    output logic      line_aux_in,
    // Receive pin
    output logic      line_rx_in
);
    // Released wire floats to the pull-up level, never the last driven value
    assign line_rx_in = line_tx_pulse_oe ? line_tx_pulse_n : 1'b1;
    // A grounded strap wins over any drive; an open pin sits at the pull-up
    assign line_aux_in = STRAP_GROUND ? 1'b0 : (line_aux_oe ? line_aux_pulse_n : 1'b1);
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import hbli_pkg::*;
    logic       clk;           // 200 MHz system clock
    logic       reset;         // Asynchronous, active high
    hbli_host_s host;          // Host bus levels
    hbli_cfg_s  cfg;           // Line configuration
    logic       tx_start;      // Frame request
    logic [7:0] tx_byte;       // Frame payload
    logic [7:0] host_rdata;    // Host read data
    logic [7:0] rx_byte;       // Received byte
    logic       strobe_style;  // Detected strobe style
    logic       bus_nonmux;    // Detected non-multiplexed bus
    logic       detect_final;  // Detections frozen
    logic       tx_busy;       // Frame in progress
    logic       tx_pulse_n;    // Transmit pin
    logic       tx_pulse_oe;   // Transmit driver enable
    logic       aux_in;        // Strap level seen by the device
    logic       aux_pulse_n;   // Auxiliary clock pin
    logic       aux_oe;        // Auxiliary driver enable
    logic       rx_in;         // Receive pin
    logic       tx_enable_pin; // Transceiver enable
    logic       rx_valid;      // Received byte strobe
    logic       arb_grant;     // Arbitration slot
    int         mismatches;    // Failed comparisons
    int         checks;        // All comparisons
    logic [7:0] rd;            // Scratch read value

    hbli_top dut_u (.clk(clk), .reset(reset), .host(host), .host_rdata(host_rdata),
        .strobe_style(strobe_style), .bus_nonmux(bus_nonmux), .detect_final(detect_final),
        .cfg(cfg), .tx_start(tx_start), .tx_byte(tx_byte), .tx_busy(tx_busy),
        .line_tx_pulse_n(tx_pulse_n), .line_tx_pulse_oe(tx_pulse_oe), .line_aux_in(aux_in),
        .line_aux_pulse_n(aux_pulse_n), .line_aux_oe(aux_oe), .line_rx_in(rx_in),
        .tx_enable_pin(tx_enable_pin), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .arb_grant(arb_grant));

    hbli_line_model #(.STRAP_GROUND(1'b1)) line_u (.line_tx_pulse_n(tx_pulse_n),
        .line_tx_pulse_oe(tx_pulse_oe), .line_aux_pulse_n(aux_pulse_n),
        .line_aux_oe(aux_oe), .line_aux_in(aux_in), .line_rx_in(rx_in));

    // Clock, 2.5 ns half period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Single exit point for the whole run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare one byte and report at once
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Same for a single bit, so an unknown still fails
    task automatic check_bit(input string what, input logic exp, input logic got);
        check(what, {7'h00, exp}, {7'h00, got});
    endtask

    // Strobe held for one cycle, then two idle cycles of spacing
    task automatic host_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        host <= {1'b0, 1'b1, 1'b0, 1'b0, a, d};
        @(posedge clk);
        host <= {1'b1, 1'b1, 1'b1, 1'b0, a, d};
        repeat (2) @(posedge clk);
    endtask

    // Read data lands one cycle after the strobe is taken
    task automatic host_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        host <= {1'b0, 1'b0, 1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        host <= {1'b1, 1'b1, 1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        #1;
        d = host_rdata;
        @(posedge clk);
    endtask

    // One raw bus cycle in any strobe style, then two idle cycles of spacing
    task automatic host_cycle(input hbli_host_s v);
        @(posedge clk);
        host <= v;
        @(posedge clk);
        host <= {1'b1, 1'b1, 1'b1, 1'b0, v.addr, 8'h00};
        repeat (2) @(posedge clk);
    endtask

    // Reset held ten cycles, line outputs inspected while it is applied
    task automatic do_reset();
        reset = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check_bit("reset tx pulse", 1'b1, tx_pulse_n);
        check_bit("reset aux pulse", 1'b1, aux_pulse_n);
        check_bit("reset tx enable", 1'b1, tx_enable_pin);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Count arbitration slots over forty cycles
    task automatic count_grants(input logic slow, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        cfg.arbiter_slowdown <= slow;
        repeat (4) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            #1;
            if (arb_grant === 1'b1) n++;
        end
        check("arb_grant count", exp, 8'(n));
    endtask

    // One frame: start, start, stop, then the byte MSB first, 40 cycles per interval
    task automatic send_frame(input logic [7:0] b, input logic pp);
        int c;
        int k;
        logic e;
        logic seen;
        logic [7:0] got;
        seen = 1'b0;
        got = 8'h00;
        @(posedge clk);
        cfg <= '{backplane: 1'b1, tx_driver_style: pp, arbiter_slowdown: 1'b0};
        tx_byte <= b;
        @(posedge clk);
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        #1;
        c = 0;
        while (tx_pulse_n !== 1'b0 && c < 100) begin
            @(posedge clk);
            #1;
            c++;
        end
        for (c = 0; c < 560; c++) begin
            k = c / 40;
            e = (k < 2) ? 1'b1 : ((k == 2) ? 1'b0 : b[(10 - k) % 8]);
            if (k < 11 && c % 40 == 10) begin
                check_bit("pulse at interval start", ~e, tx_pulse_n);
                check_bit("aux clock low", 1'b0, aux_pulse_n);
                if (e) check_bit("enable during pulse", 1'b1, tx_enable_pin);
            end
            if (k < 11 && c % 40 == 30) begin
                check_bit("pulse late in interval", 1'b1, tx_pulse_n);
                check_bit("driver enable style", pp, tx_pulse_oe);
                check_bit("aux driver on", 1'b1, aux_oe);
            end
            if (c == 400) check_bit("busy in last interval", 1'b1, tx_busy);
            if (c == 500) check_bit("busy after frame", 1'b0, tx_busy);
            if (c == 500) check_bit("idle line", 1'b1, tx_pulse_n);
            if (c == 500) check_bit("enable idle", 1'b0, tx_enable_pin);
            if (rx_valid === 1'b1) begin
                seen = 1'b1;
                got = rx_byte;
            end
            @(posedge clk);
            #1;
        end
        check_bit("rx_valid seen", 1'b1, seen);
        check("rx_byte", b, got);
    endtask

    // Guard against a hang, well beyond the expected run of about 1320 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("mismatch watchdog expected finish seen timeout");
        tally_and_finish();
    end

    // Test sequence
    initial begin
        logic [7:0] pat [3];
        pat = '{8'hA5, 8'h5A, 8'h3C};
        mismatches = 0;
        checks = 0;
        host = {1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 8'h00};
        cfg = '{backplane: 1'b1, tx_driver_style: 1'b0, arbiter_slowdown: 1'b0};
        tx_start = 1'b0;
        tx_byte = 8'h00;
        do_reset();
        check_bit("style default", 1'b0, strobe_style);
        check_bit("nonmux default", 1'b0, bus_nonmux);
        host_write(HBLI_REG_PTR_HIGH, 8'h40);
        check_bit("nonmux after even write", 1'b0, bus_nonmux);
        host_write(HBLI_REG_PTR_LOW, 8'h10);
        check_bit("nonmux after odd write", 1'b1, bus_nonmux);
        check_bit("final before read", 1'b0, detect_final);
        host_read(HBLI_REG_PTR_LOW, rd);
        check_bit("final after read", 1'b1, detect_final);
        check_bit("style kept", 1'b0, strobe_style);
        host_read(HBLI_REG_STATUS, rd);
        check("status", 8'h06, rd);
        host_read(3'h7, rd);
        check("unmapped read", 8'h00, rd);
        $display("test detect done");
        for (int i = 0; i < 3; i++) host_write(HBLI_REG_DATA, pat[i]);
        host_write(HBLI_REG_PTR_HIGH, 8'hC0);
        host_write(HBLI_REG_PTR_LOW, 8'h10);
        for (int i = 0; i < 3; i++) begin
            host_read(HBLI_REG_DATA, rd);
            check("sequential read", pat[i], rd);
        end
        host_write(HBLI_REG_PTR_HIGH, 8'h80);
        host_write(HBLI_REG_PTR_LOW, 8'h11);
        for (int i = 0; i < 2; i++) begin
            host_read(HBLI_REG_DATA, rd);
            check("fixed pointer read", 8'h5A, rd);
        end
        check_bit("nonmux still held", 1'b1, bus_nonmux);
        $display("test ram done");
        count_grants(1'b0, 8'd40);
        count_grants(1'b1, 8'd10);
        $display("test arbitration done");
        send_frame(8'hA5, 1'b0);
        send_frame(8'h3C, 1'b1);
        $display("test line done");
        do_reset();
        check_bit("style after reset", 1'b0, strobe_style);
        check_bit("nonmux after reset", 1'b0, bus_nonmux);
        check_bit("final after reset", 1'b0, detect_final);
        host_cycle({1'b0, 1'b0, 1'b0, 1'b0, HBLI_REG_PTR_HIGH, 8'h00});
        check_bit("nonmux after even access", 1'b0, bus_nonmux);
        check_bit("direction style", 1'b1, strobe_style);
        host_cycle({1'b0, 1'b1, 1'b0, 1'b0, HBLI_REG_STATUS, 8'h00});
        check("status direction style", 8'h01, host_rdata);
        $display("test rereset done");
        tally_and_finish();
    end
endmodule
